// >>> timer_b_cfg.svh
// Behaviour
// - Prescale codes 000 to 110 advance the counter at the bus clock divided by 1, 2, 4, 8, 16, 32 or 64.
// - Prescale code 111 advances the counter on rising edges of the external timer clock input instead.
// - Reset forces the prescale select field to zero, so the counter runs at the undivided bus clock.
// - The counter is read through two read-only byte registers, high and low, and writes to them do nothing.
// - Reading the high byte captures the low byte into a holding buffer that the next low-byte read returns.
// - While the low byte is held, more high-byte reads do not refresh it; a low-byte read or a counter-reset write releases it.
// - Reset clears the counter to zero.
// - Writing one to the counter-reset control bit clears the counter to zero.
// - A hold taken during a break persists after the break until a low-byte read or a counter-reset write happens.
`ifndef TIMER_B_CFG_SVH
`define TIMER_B_CFG_SVH
`define TB_ADDR_CTRL       12'h000
`define TB_ADDR_CNT_HIGH   12'h004
`define TB_ADDR_CNT_LOW    12'h008
`define TB_PS_LSB          0
`define TB_PS_MSB          2
`define TB_TRST_BIT        4
`define TB_PS_RESET        3'h0
`define TB_PS_EXTERNAL     3'h7
`define TB_CNT_RESET       16'h0000
`define TB_CNT_ONE         16'h0001
`define TB_DIV_RESET       6'h00
`define TB_DIV_ONE         6'h01
`define TB_ZERO32          32'h0000_0000
`endif

// >>> timer_b_pkg.sv
package timer_b_pkg;
   // apb request as seen by the slave
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   // hold state of the low-byte latch
   typedef enum logic [0:0] {
      HOLD_IDLE = 1'b0,
      HOLD_LATCHED = 1'b1
   } hold_state_t;

   // whole state of the top module
   typedef struct packed {
      logic [2:0]  prescale;
      logic [15:0] count;
      logic [7:0]  lowHeld;
      hold_state_t hold;
      logic        extPrev;
      logic        ack;
      logic [31:0] prdata;
   } timer_state_t;

   // state of the prescaler
   typedef struct packed {
      logic [5:0] div;
      logic       tick;
   } presc_state_t;
endpackage

// >>> timer_b_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer_b_cfg.svh"
module timer_b_prescaler
   import timer_b_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   input  wire logic       clkEn,
   input  wire logic [2:0] prescale,
   input  wire logic       extEdge,
   input  wire logic       clear,
   output logic            tick
);
   presc_state_t stateFf;
   presc_state_t nxtState;
   logic [5:0]   mask;

   // divide ratio as a mask of low divider bits; code 0 gives an all-zero mask
   always_comb begin
      mask = 6'((7'h01 << prescale) - 7'h01);
   end

   // free divider; a tick fires when the masked bits are all ones
   always_comb begin
      nxtState = stateFf;
      nxtState.tick = 1'b0;
      if (clear) begin
         nxtState.div = `TB_DIV_RESET;
      end else if (prescale == `TB_PS_EXTERNAL) begin
         nxtState.tick = extEdge;
         nxtState.div = `TB_DIV_RESET;
      end else begin
         nxtState.tick = ((stateFf.div & mask) == mask);
         nxtState.div = (nxtState.tick) ? `TB_DIV_RESET : 6'(stateFf.div + `TB_DIV_ONE);
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         stateFf <= '0;
      end else if (clkEn) begin
         stateFf <= nxtState;
      end
   end

   // registered tick: one cycle of latency, equal for every ratio
   assign tick = stateFf.tick;
endmodule // timer_b_prescaler
`default_nettype wire

// >>> timer_b_apb_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer_b_cfg.svh"
module timer_b_apb_decode
   import timer_b_pkg::*;
(
   input  wire apb_req_t req,
   output logic          wrCtrl,
   output logic          rdCtrl,
   output logic          rdHigh,
   output logic          rdLow,
   output logic          unmapped
);
   logic access;

   // strobes valid in the whole access phase; the caller acts on its first cycle only
   always_comb begin
      access   = req.psel && req.penable;
      wrCtrl   = access && req.pwrite && (req.paddr == `TB_ADDR_CTRL);
      rdCtrl   = access && !req.pwrite && (req.paddr == `TB_ADDR_CTRL);
      rdHigh   = access && !req.pwrite && (req.paddr == `TB_ADDR_CNT_HIGH);
      rdLow    = access && !req.pwrite && (req.paddr == `TB_ADDR_CNT_LOW);
      unmapped = access && (req.paddr != `TB_ADDR_CTRL) && (req.paddr != `TB_ADDR_CNT_HIGH)
                 && (req.paddr != `TB_ADDR_CNT_LOW);
   end
endmodule // timer_b_apb_decode
`default_nettype wire

// >>> timer_b_counter.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer_b_cfg.svh"
module timer_b_counter
   import timer_b_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        clkEn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        extTimerClk,
   output logic [15:0]      countValue
);
   timer_state_t stateFf;
   timer_state_t nxtState;
   apb_req_t     req;
   logic         wrCtrl;
   logic         rdCtrl;
   logic         rdHigh;
   logic         rdLow;
   logic         unmapped;
   logic         wrCtrlDec;
   logic         rdCtrlDec;
   logic         rdHighDec;
   logic         rdLowDec;
   logic         unmappedDec;
   logic         tick;
   logic         clearCnt;
   logic         extEdge;

   // bundle the bus request
   always_comb begin
      req.psel    = psel;
      req.penable = penable;
      req.pwrite  = pwrite;
      req.paddr   = paddr;
      req.pwdata  = pwdata;
   end

   timer_b_apb_decode u_decode (
      .req      (req),
      .wrCtrl   (wrCtrlDec),
      .rdCtrl   (rdCtrlDec),
      .rdHigh   (rdHighDec),
      .rdLow    (rdLowDec),
      .unmapped (unmappedDec)
   );

   // act once, in the first access cycle; the second cycle presents the registered answer and flags an unmapped address
   assign wrCtrl   = wrCtrlDec && !stateFf.ack;
   assign rdCtrl   = rdCtrlDec && !stateFf.ack;
   assign rdHigh   = rdHighDec && !stateFf.ack;
   assign rdLow    = rdLowDec && !stateFf.ack;
   assign unmapped = unmappedDec && stateFf.ack;

   // counter-reset bit is self-clearing: it acts on the write and reads back zero
   assign clearCnt = wrCtrl && pwdata[`TB_TRST_BIT];

   // rising edge of the external pin, taken as synchronous to clk_sys
   assign extEdge = extTimerClk && !stateFf.extPrev;

   timer_b_prescaler u_presc (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .clkEn    (clkEn),
      .prescale (stateFf.prescale),
      .extEdge  (extEdge),
      .clear    (clearCnt),
      .tick     (tick)
   );

   // next state: control field, counter, low-byte hold and read data
   always_comb begin
      nxtState = stateFf;
      nxtState.extPrev = extTimerClk;
      // one wait state, so the registered read data stands when pready is sampled high
      nxtState.ack = psel && penable && !stateFf.ack;
      if (wrCtrl) begin
         nxtState.prescale = pwdata[`TB_PS_MSB:`TB_PS_LSB];
      end
      // clear beats a tick in the same cycle so the write always lands on zero
      if (clearCnt) begin
         nxtState.count = `TB_CNT_RESET;
      end else if (tick) begin
         nxtState.count = 16'(stateFf.count + `TB_CNT_ONE);
      end
      // reads of control and counter bytes; writes to the counter bytes fall through with no effect
      nxtState.prdata = `TB_ZERO32;
      if (rdCtrl) begin
         nxtState.prdata = {29'h0000_0000, stateFf.prescale};
      end
      if (rdHigh) begin
         nxtState.prdata = {24'h00_0000, stateFf.count[15:8]};
         if (stateFf.hold == HOLD_IDLE) begin
            nxtState.lowHeld = stateFf.count[7:0];
            nxtState.hold = HOLD_LATCHED;
         end
         // already held: keep the earlier capture, no break special case needed
      end
      if (rdLow) begin
         // a held value survives any break until this read or a counter-reset write releases it
         nxtState.prdata = {24'h00_0000, (stateFf.hold == HOLD_LATCHED) ? stateFf.lowHeld
                                                                         : stateFf.count[7:0]};
         nxtState.hold = HOLD_IDLE;
      end
      if (clearCnt) begin
         nxtState.hold = HOLD_IDLE;
      end
   end

   // single state register; reset clears counter and prescale field
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         stateFf          <= '0;
         stateFf.prescale <= `TB_PS_RESET;
         stateFf.count    <= `TB_CNT_RESET;
         stateFf.hold     <= HOLD_IDLE;
      end else if (clkEn) begin
         stateFf <= nxtState;
      end
   end

   // read data is registered: pready rises in the second access cycle, with the data in place
   assign prdata     = stateFf.prdata;
   assign pready     = !(psel && penable) || stateFf.ack;
   assign pslverr    = unmapped;
   assign countValue = stateFf.count;
endmodule // timer_b_counter
`default_nettype wire

// >>> timer_b_sva.sv
`timescale 1ns/10ps
`default_nettype none
module timer_b_sva (
   input wire logic        clk_sys,
   input wire logic        nrst,
   input wire logic        clkEn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        extTimerClk,
   input wire logic [15:0] countValue
);
   logic       acc, rdH, rdL, clr, heldFf;
   logic [7:0] lowFf;
   // decoded access strobes
   assign acc = psel && penable && !pready && clkEn;
   assign rdH = acc && !pwrite && paddr == 12'h004;
   assign rdL = acc && !pwrite && paddr == 12'h008;
   assign clr = acc && pwrite && paddr == 12'h000 && pwdata[4];
   // shadow of the low-byte hold; a clear drops it as well
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         heldFf <= 1'b0;
         lowFf <= 8'h00;
      end else if (rdL || clr) begin
         heldFf <= 1'b0;
      end else if (rdH && !heldFf) begin
         heldFf <= 1'b1;
         lowFf <= countValue[7:0];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   ready_high_a: assert property (acc |=> pready)
      else $error("pready not high after one wait");
   unmapped_err_a: assert property (psel && penable && pready && paddr > 12'h008 |-> pslverr)
      else $error("no error on unmapped address");
   err_data_a: assert property (acc && !pwrite && paddr > 12'h008 |=> prdata == 32'h0000_0000)
      else $error("unmapped read data not zero");
   count_step_a: assert property (!$stable(countValue) |-> countValue == $past(countValue) + 16'h0001 || countValue == 16'h0000)
      else $error("counter jumped");
   freeze_en_a: assert property (!clkEn |=> $stable(countValue))
      else $error("counter moved while disabled");
   rst_zero_a: assert property (disable iff (1'b0) !nrst |-> countValue == 16'h0000)
      else $error("counter not zero in reset");
   clear_zero_a: assert property (clr |-> ##[1:2] countValue == 16'h0000)
      else $error("counter not cleared");
   high_read_a: assert property (rdH |=> prdata[7:0] == $past(countValue[15:8]))
      else $error("high byte read wrong");
   held_read_a: assert property (rdL && heldFf |=> prdata[7:0] == lowFf)
      else $error("held low byte wrong");
   cover property (rdL && heldFf);
   cover property (clr);
   cover property (pslverr);
endmodule // timer_b_sva
bind timer_b_counter timer_b_sva u_sva (.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .extTimerClk(extTimerClk), .countValue(countValue));
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        clk_sys = 1'b0, nrst = 1'b0, clkEn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        extTimerClk = 1'b0, pready, pslverr, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [15:0] countValue, a, b, v;
   int          n_mismatch = 0, checked = 0;
   always #10 clk_sys = ~clk_sys;
   timer_b_counter u_timer_b_counter (.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .extTimerClk(extTimerClk), .countValue(countValue));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; request held until pready is sampled high, data taken at that edge
   task automatic acc(input logic w, input logic [11:0] ad, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      err = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic snap(output logic [15:0] s);
      @(posedge clk_sys);
      #1 s = countValue;
   endtask
   // external clock pulses, two cycles high and three low, then pipeline settles
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge clk_sys) extTimerClk <= 1'b1;
         repeat (2) @(posedge clk_sys);
         extTimerClk <= 1'b0;
         repeat (2) @(posedge clk_sys);
      end
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic t_reset;
      acc(1'b0, 12'h000, 32'h0000_0000);
      chk({13'h0000, rd[2:0]}, 16'h0000);
      snap(a);
      snap(b);
      chk(b - a, 16'h0001);
   endtask
   task automatic t_rate;
      for (int c = 0; c < 7; c++) begin
         acc(1'b1, 12'h000, 32'h0000_0010 + 32'(c));
         snap(a);
         repeat (127) @(posedge clk_sys);
         snap(b);
         chk(b - a, 16'h0080 >> c);
      end
   endtask
   task automatic t_ext;
      acc(1'b1, 12'h000, 32'h0000_0017);
      snap(a);
      chk(a, 16'h0000);
      pulse(5);
      snap(b);
      chk(b, 16'h0005);
   endtask
   task automatic t_latch;
      acc(1'b1, 12'h000, 32'h0000_0000);
      repeat (300) @(posedge clk_sys);
      acc(1'b1, 12'h000, 32'h0000_0007);
      snap(v);
      acc(1'b0, 12'h004, 32'h0000_0000);
      chk({8'h00, rd[7:0]}, {8'h00, v[15:8]});
      pulse(3);
      acc(1'b0, 12'h004, 32'h0000_0000);
      chk({8'h00, rd[7:0]}, {8'h00, 8'((v + 16'h0003) >> 8)});
      acc(1'b0, 12'h008, 32'h0000_0000);
      chk({8'h00, rd[7:0]}, {8'h00, v[7:0]});
      acc(1'b0, 12'h008, 32'h0000_0000);
      chk({8'h00, rd[7:0]}, {8'h00, 8'(v + 16'h0003)});
      acc(1'b1, 12'h004, 32'h0000_00FF);
      acc(1'b1, 12'h008, 32'h0000_00FF);
      snap(a);
      chk(a, v + 16'h0003);
      acc(1'b0, 12'h00C, 32'h0000_0000);
      chk({15'h0000, err}, 16'h0001);
      chk(rd[15:0], 16'h0000);
   endtask
   task automatic t_en;
      acc(1'b1, 12'h000, 32'h0000_0000);
      @(posedge clk_sys) clkEn <= 1'b0;
      snap(a);
      repeat (4) @(posedge clk_sys);
      snap(b);
      chk(b, a);
      @(posedge clk_sys) clkEn <= 1'b1;
   endtask
   task automatic test_done;
      $display("mismatches %0d comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      t_reset();
      t_rate();
      t_ext();
      t_latch();
      t_en();
      test_done();
   end
   // watchdog, about fifteen times the expected run
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      test_done();
   end
endmodule // testbench
`default_nettype wire
